// ---- shared/kll_regs.vh ----
// register map, key codes, display kinds and timing for the keypad controller
`ifndef KLL_REGS_VH
`define KLL_REGS_VH
`define KLL_A_KEY     8'h00
`define KLL_A_CFG     8'h04
`define KLL_A_STAT    8'h08
`define KLL_A_DISP    8'h0C
`define KLL_A_KIND    8'h10
`define KLL_A_PRESET  8'h14
`define KLL_A_PREWARN 8'h18
`define KLL_A_BATCH   8'h1C
`define KLL_A_GRAND   8'h20
`define KLL_A_RATE    8'h24
`define KLL_A_LOCK    8'h28
`define KLL_A_EFFK    8'h2C
`define KLL_A_FTAB    2'h1
`define KLL_A_KTAB    2'h2
`define KLL_CFG_PRE   0
`define KLL_CFG_WARN  1
`define KLL_CFG_UNIT  3:2
`define KLL_CFG_CAL   4
`define KLL_K_CONF    5'h0A
`define KLL_K_ERASE   5'h0B
`define KLL_K_VIEW    5'h0C
`define KLL_K_START   5'h0D
`define KLL_K_STOP    5'h0E
`define KLL_K_MENU    5'h0F
`define KLL_D_NUM     4'h0
`define KLL_D_RATE    4'h1
`define KLL_D_GRAND   4'h2
`define KLL_D_POINT   4'h3
`define KLL_D_FREQ    4'h4
`define KLL_D_KF      4'h5
`define KLL_D_LOCKON  4'h6
`define KLL_D_LOCKOFF 4'h7
`define KLL_D_SEQERR  4'h8
`define KLL_D_WARN    4'h9
`define KLL_MAXPT     5'h10
`define KLL_LOCK_RST  16'h1000
`define KLL_UNITY     32'h0000_0001
`define KLL_MIN_SC    16'h003C
`define KLL_HR_SC     16'h0E10
`define KLL_MSG_MS    1000
`define KLL_CLK_KHZ   40000
`endif

// ---- logic/kll_keypad.v ----
// keypad, display view, totalizer clear, lockout and linearization table entry
`timescale 1ns/1ps
`default_nettype none
`include "kll_regs.vh"
// Notes on behaviour
// - calibration mode forces the divider factor to one at every point
// - confirm on point zero leaves table setup for run
// - point numbers above sixteen are clamped to sixteen
// - selecting a point shows its frequency; erase, digits, confirm stores then factor
// - factor shown, erased or keyed; confirm stores it and advances the point
// - on exit a bad ordering flashes an error then shows the bad point
// - erase during point selection returns selector to point zero
// - run entry shows the batch total as it stands, or a pending warning
// - batch plain, rate with marker, grand total flashing
// - view key swaps rate and batch; confirm toggles grand total view
// - erase clears batch in run, batch view, unlocked; shows preset or zero
// - erase clears grand total in run, grand view, unlocked
// - external reset level clears the batch even when locked
// - unlocked after reset, code 1000, code toggles lock with brief message
// - locked blocks grand clear, setup and settings except preset and rate
// - locked still counts, displays, and honours start, stop and view keys
// - lock code compared against the last four digits keyed in run
// - rate view scales base rate by one, sixty or 3600
module kll_keypad #(
  parameter [31:0] MSG_CYC = `KLL_MSG_MS * `KLL_CLK_KHZ
) (
  input  wire        CLK_IN,      // 40 MHz clock
  input  wire        RST_N_IN,    // async reset, active low
  input  wire [7:0]  AWADDR_IN,   // write address
  input  wire        AWVALID_IN,  // write address valid
  output reg         AWREADY_OUT, // write address ready
  input  wire [31:0] WDATA_IN,    // write data
  input  wire [3:0]  WSTRB_IN,    // byte enables
  input  wire        WVALID_IN,   // write data valid
  output reg         WREADY_OUT,  // write data ready
  output reg  [1:0]  BRESP_OUT,   // write response
  output reg         BVALID_OUT,  // write response valid
  input  wire        BREADY_IN,   // write response ready
  input  wire [7:0]  ARADDR_IN,   // read address
  input  wire        ARVALID_IN,  // read address valid
  output reg         ARREADY_OUT, // read address ready
  output reg  [31:0] RDATA_OUT,   // read data
  output reg  [1:0]  RRESP_OUT,   // read response
  output reg         RVALID_OUT,  // read data valid
  input  wire        RREADY_IN,   // read data ready
  input  wire        PULSE_IN,    // counted input, async
  input  wire        EXT_RST_IN   // batch reset level, async
);
  localparam ST_RUN = 3'd0;
  localparam ST_PT  = 3'd1;
  localparam ST_FRQ = 3'd2;
  localparam ST_KF  = 3'd3;
  localparam ST_ERR = 3'd4;

  reg  [2:0]  st_r;
  reg  [4:0]  ptr_r;
  reg  [4:0]  npts_r;
  reg  [31:0] acc_r;
  reg         rate_view_r;
  reg         grand_view_r;
  reg         init_r;
  reg         locked_r;
  reg         started_r;
  reg  [15:0] code_r;
  reg  [15:0] hist_r;
  reg  [3:0]  msg_r;
  reg  [31:0] msg_cnt_r;
  reg  [4:0]  cfg_r;
  reg  [31:0] preset_r;
  reg  [31:0] prewarn_r;
  reg  [31:0] rate_r;
  reg  [31:0] batch_r;
  reg  [31:0] grand_r;
  reg  [31:0] ftab [0:15];
  reg  [31:0] ktab [0:15];
  reg         p1_r;
  reg         p2_r;
  reg         p3_r;
  reg         e1_r;
  reg         e2_r;
  reg         up_r;
  reg         aw_got_r;
  reg         w_got_r;
  reg  [7:0]  aw_a_r;
  reg  [31:0] w_d_r;
  reg  [3:0]  w_s_r;
  reg  [31:0] rd_d;
  reg         rd_ok;
  reg  [3:0]  kind;
  reg  [31:0] dval;
  reg         bad;
  reg  [4:0]  badp;
  reg         clr_b;
  reg         clr_g;
  wire        wen;
  wire        key_ev;
  wire [4:0]  key;
  wire [3:0]  dig;
  wire        is_dig;
  wire [31:0] acc_dig;
  wire [15:0] hist_nxt;
  wire [4:0]  pt_clamp;
  wire [3:0]  pidx;
  wire [47:0] rate_prod;
  wire        inc;
  wire [31:0] b_base;
  wire [31:0] g_base;
  wire [31:0] effk;
  integer     i;
  integer     k;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer      j;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        merge[8*j +: 8] = s[j] ? d[8*j +: 8] : old[8*j +: 8];
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `KLL_A_EFFK || a[7:6] == `KLL_A_FTAB || a[7:6] == `KLL_A_KTAB);
    end
  endfunction

  function [15:0] unit_scale;
    input [1:0] u;
    begin
      case (u)
        2'd0:    unit_scale = 16'h0001;
        2'd1:    unit_scale = `KLL_MIN_SC;
        default: unit_scale = `KLL_HR_SC;
      endcase
    end
  endfunction

  assign wen       = aw_got_r & w_got_r & ~BVALID_OUT;
  assign key_ev    = wen && aw_a_r == `KLL_A_KEY && w_s_r[0];
  assign key       = w_d_r[4:0];
  assign dig       = key[3:0];
  assign is_dig    = key <= 5'h09;
  // each digit multiplies by ten and appends
  assign acc_dig   = {acc_r[28:0], 3'b000} + {acc_r[30:0], 1'b0} + {28'h000_0000, dig};
  assign hist_nxt  = {hist_r[11:0], dig};
  assign pt_clamp  = (acc_r > {27'h000_0000, `KLL_MAXPT}) ? `KLL_MAXPT : acc_r[4:0];
  assign pidx      = ptr_r[3:0] - 4'h1;
  assign rate_prod = rate_r * unit_scale(cfg_r[`KLL_CFG_UNIT]);
  assign inc       = p2_r & ~p3_r;
  assign b_base    = (clr_b | e2_r) ? (cfg_r[`KLL_CFG_PRE] ? preset_r : 32'h0000_0000) : batch_r;
  assign g_base    = clr_g ? 32'h0000_0000 : grand_r;
  assign effk      = cfg_r[`KLL_CFG_CAL] ? `KLL_UNITY : ktab[pidx];

  // erase in run: lockout blocks both clears
  always @* begin
    clr_b = key_ev && st_r == ST_RUN && key == `KLL_K_ERASE && !locked_r && !grand_view_r && !rate_view_r;
    clr_g = key_ev && st_r == ST_RUN && key == `KLL_K_ERASE && !locked_r && grand_view_r;
  end

  // first point must be zero, then strictly rising
  always @* begin
    bad  = 1'b0;
    badp = 5'h00;
    for (i = 1; i <= 16; i = i + 1) begin
      if (!bad && i <= npts_r) begin
        if (i == 1 ? ftab[0] != 32'h0000_0000 : ftab[i-1] <= ftab[i-2]) begin
          bad  = 1'b1;
          badp = i[4:0];
        end
      end
    end
  end

  always @* begin
    kind = `KLL_D_NUM;
    dval = batch_r;
    if (msg_cnt_r != 32'h0000_0000) begin
      kind = msg_r;
      dval = {27'h000_0000, ptr_r};
    end else begin
      case (st_r)
        ST_RUN: begin
          if (init_r && cfg_r[`KLL_CFG_WARN]) begin
            kind = `KLL_D_WARN;
          end else if (grand_view_r) begin
            kind = `KLL_D_GRAND;
            dval = grand_r;
          end else if (rate_view_r) begin
            kind = `KLL_D_RATE;
            dval = rate_prod[31:0];
          end
        end
        ST_PT: begin
          kind = `KLL_D_POINT;
          dval = acc_r;
        end
        ST_FRQ: begin
          kind = `KLL_D_FREQ;
          dval = acc_r;
        end
        ST_KF: begin
          kind = `KLL_D_KF;
          dval = acc_r;
        end
        default: begin
          kind = `KLL_D_POINT;
          dval = {27'h000_0000, ptr_r};
        end
      endcase
    end
  end

  always @* begin
    rd_ok = mapped(ARADDR_IN);
    rd_d  = 32'h0000_0000;
    case (ARADDR_IN)
      `KLL_A_CFG:     rd_d = {27'h000_0000, cfg_r};
      `KLL_A_STAT:    rd_d = {15'h0000, badp, ptr_r, started_r, locked_r, grand_view_r, rate_view_r, st_r};
      `KLL_A_DISP:    rd_d = dval;
      `KLL_A_KIND:    rd_d = {28'h000_0000, kind};
      `KLL_A_PRESET:  rd_d = preset_r;
      `KLL_A_PREWARN: rd_d = prewarn_r;
      `KLL_A_BATCH:   rd_d = batch_r;
      `KLL_A_GRAND:   rd_d = grand_r;
      `KLL_A_RATE:    rd_d = rate_r;
      `KLL_A_LOCK:    rd_d = locked_r ? 32'h0000_0000 : {16'h0000, code_r};
      `KLL_A_EFFK:    rd_d = effk;
      default: begin
        if (ARADDR_IN[7:6] == `KLL_A_FTAB) begin
          rd_d = ftab[ARADDR_IN[5:2]];
        end else if (ARADDR_IN[7:6] == `KLL_A_KTAB) begin
          rd_d = ktab[ARADDR_IN[5:2]];
        end
      end
    endcase
  end

  // bus slave: address and data may arrive in either order
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      up_r        <= 1'b0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
      ARREADY_OUT <= 1'b0;
      BVALID_OUT  <= 1'b0;
      BRESP_OUT   <= 2'b00;
      RVALID_OUT  <= 1'b0;
      RRESP_OUT   <= 2'b00;
      RDATA_OUT   <= 32'h0000_0000;
      aw_got_r    <= 1'b0;
      w_got_r     <= 1'b0;
      aw_a_r      <= 8'h00;
      w_d_r       <= 32'h0000_0000;
      w_s_r       <= 4'h0;
    end else begin
      if (!up_r) begin
        up_r        <= 1'b1;
        AWREADY_OUT <= 1'b1;
        WREADY_OUT  <= 1'b1;
        ARREADY_OUT <= 1'b1;
      end
      if (AWVALID_IN && AWREADY_OUT) begin
        AWREADY_OUT <= 1'b0;
        aw_got_r    <= 1'b1;
        aw_a_r      <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        WREADY_OUT <= 1'b0;
        w_got_r    <= 1'b1;
        w_d_r      <= WDATA_IN;
        w_s_r      <= WSTRB_IN;
      end
      if (wen) begin
        aw_got_r   <= 1'b0;
        w_got_r    <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= mapped(aw_a_r) ? 2'b00 : 2'b10;
      end
      if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT  <= 1'b0;
        AWREADY_OUT <= 1'b1;
        WREADY_OUT  <= 1'b1;
      end
      if (ARVALID_IN && ARREADY_OUT) begin
        ARREADY_OUT <= 1'b0;
        RVALID_OUT  <= 1'b1;
        RDATA_OUT   <= rd_d;
        RRESP_OUT   <= rd_ok ? 2'b00 : 2'b10;
      end
      if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT  <= 1'b0;
        ARREADY_OUT <= 1'b1;
      end
    end
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r         <= ST_RUN;
      ptr_r        <= 5'h00;
      npts_r       <= 5'h00;
      acc_r        <= 32'h0000_0000;
      rate_view_r  <= 1'b0;
      grand_view_r <= 1'b0;
      init_r       <= 1'b1;
      locked_r     <= 1'b0;
      started_r    <= 1'b0;
      code_r       <= `KLL_LOCK_RST;
      hist_r       <= 16'h0000;
      msg_r        <= `KLL_D_NUM;
      msg_cnt_r    <= 32'h0000_0000;
      cfg_r        <= 5'h00;
      preset_r     <= 32'h0000_0000;
      prewarn_r    <= 32'h0000_0000;
      rate_r       <= 32'h0000_0000;
      batch_r      <= 32'h0000_0000;
      grand_r      <= 32'h0000_0000;
      p1_r         <= 1'b0;
      p2_r         <= 1'b0;
      p3_r         <= 1'b0;
      e1_r         <= 1'b0;
      e2_r         <= 1'b0;
      for (k = 0; k < 16; k = k + 1) begin
        ftab[k] <= 32'h0000_0000;
        ktab[k] <= 32'h0000_0000;
      end
    end else begin
      p1_r <= PULSE_IN;
      p2_r <= p1_r;
      p3_r <= p2_r;
      e1_r <= EXT_RST_IN;
      e2_r <= e1_r;
      // counting never stops, whatever the lock or mode; a pulse landing on a clear still counts
      batch_r <= cfg_r[`KLL_CFG_PRE] ? b_base - {31'h0000_0000, inc} : b_base + {31'h0000_0000, inc};
      grand_r <= g_base + {31'h0000_0000, inc};
      if (msg_cnt_r != 32'h0000_0000) begin
        msg_cnt_r <= msg_cnt_r - 32'h0000_0001;
      end
      if (wen && aw_a_r == `KLL_A_PRESET) begin
        preset_r <= merge(preset_r, w_d_r, w_s_r);
      end
      if (wen && aw_a_r == `KLL_A_RATE) begin
        rate_r <= merge(rate_r, w_d_r, w_s_r);
      end
      if (wen && !locked_r) begin
        if (aw_a_r == `KLL_A_CFG && w_s_r[0]) begin
          cfg_r <= w_d_r[4:0];
        end
        if (aw_a_r == `KLL_A_PREWARN) begin
          prewarn_r <= merge(prewarn_r, w_d_r, w_s_r);
        end
        if (aw_a_r == `KLL_A_LOCK) begin
          code_r <= {w_s_r[1] ? w_d_r[15:8] : code_r[15:8], w_s_r[0] ? w_d_r[7:0] : code_r[7:0]};
        end
      end
      case (st_r)
        ST_RUN: begin
          if (key_ev) begin
            init_r <= 1'b0;
            if (is_dig) begin
              hist_r <= hist_nxt;
              if (hist_nxt == code_r) begin
                locked_r  <= ~locked_r;
                msg_r     <= locked_r ? `KLL_D_LOCKOFF : `KLL_D_LOCKON;
                msg_cnt_r <= MSG_CYC;
              end
            end else if (key == `KLL_K_CONF) begin
              grand_view_r <= ~grand_view_r;
            end else if (key == `KLL_K_VIEW) begin
              rate_view_r <= ~rate_view_r;
            end else if (key == `KLL_K_START) begin
              started_r <= 1'b1;
            end else if (key == `KLL_K_STOP) begin
              started_r <= 1'b0;
            end else if (key == `KLL_K_MENU && !locked_r && !started_r) begin
              st_r  <= ST_PT;
              acc_r <= 32'h0000_0000;
            end
          end
        end
        ST_PT: begin
          if (key_ev && is_dig) begin
            acc_r <= acc_dig;
          end else if (key_ev && key == `KLL_K_ERASE) begin
            acc_r <= 32'h0000_0000;
            ptr_r <= 5'h00;
          end else if (key_ev && key == `KLL_K_CONF) begin
            if (acc_r == 32'h0000_0000) begin
              if (bad) begin
                st_r      <= ST_ERR;
                ptr_r     <= badp;
                msg_r     <= `KLL_D_SEQERR;
                msg_cnt_r <= MSG_CYC;
              end else begin
                st_r         <= ST_RUN;
                init_r       <= 1'b1;
                grand_view_r <= 1'b0;
                rate_view_r  <= 1'b0;
              end
            end else begin
              ptr_r <= pt_clamp;
              acc_r <= ftab[pt_clamp[3:0] - 4'h1];
              st_r  <= ST_FRQ;
            end
          end
        end
        ST_FRQ: begin
          if (key_ev && is_dig) begin
            acc_r <= acc_dig;
          end else if (key_ev && key == `KLL_K_ERASE) begin
            acc_r <= 32'h0000_0000;
          end else if (key_ev && key == `KLL_K_CONF) begin
            ftab[pidx] <= acc_r;
            acc_r      <= ktab[pidx];
            st_r       <= ST_KF;
          end
        end
        ST_KF: begin
          if (key_ev && is_dig) begin
            acc_r <= acc_dig;
          end else if (key_ev && key == `KLL_K_ERASE) begin
            acc_r <= 32'h0000_0000;
          end else if (key_ev && key == `KLL_K_CONF) begin
            ktab[pidx] <= acc_r;
            if (ptr_r > npts_r) begin
              npts_r <= ptr_r;
            end
            // past the last point the selector lands on zero, ready to exit
            ptr_r <= (ptr_r == `KLL_MAXPT) ? 5'h00 : ptr_r + 5'h01;
            acc_r <= (ptr_r == `KLL_MAXPT) ? 32'h0000_0000 : {27'h000_0000, ptr_r + 5'h01};
            st_r  <= ST_PT;
          end
        end
        default: begin
          if (msg_cnt_r == 32'h0000_0001) begin
            st_r  <= ST_PT;
            acc_r <= {27'h000_0000, ptr_r};
          end
        end
      endcase
    end
  end
endmodule // kll_keypad
`default_nettype wire

// ---- tb/kll_field_src.sv ----
// field-side pulse source feeding the counted input
`timescale 1ns/1ps
`default_nettype none
module kll_field_src (
  input  wire logic       clk_in,   // bench clock
  input  wire logic [3:0] burst_in, // pulses per burst
  input  wire logic       go_in,    // start a burst
  output var  logic       pulse_out // counted input line
);
  logic [4:0] left_r = 5'h00;
  initial pulse_out = 1'b0;
  // one cycle high, one low: fastest edge rate the sync path must resolve
  always @(posedge clk_in) begin
    if (go_in) begin
      left_r <= {burst_in, 1'b0};
    end else if (left_r != 5'h00) begin
      left_r <= left_r - 5'h01;
    end
    pulse_out <= left_r[0];
  end
endmodule // kll_field_src
`default_nettype wire

// ---- tb/kll_keypad_checker.sv ----
// bus timing checks on the keypad controller ports
`timescale 1ns/1ps
`default_nettype none
`include "kll_regs.vh"
module kll_keypad_checker (
  input wire logic        CLK_IN,      // clock
  input wire logic        RST_N_IN,    // reset, active low
  input wire logic        AWVALID_IN,  // aw valid
  input wire logic        AWREADY_OUT, // aw ready
  input wire logic        WVALID_IN,   // w valid
  input wire logic        WREADY_OUT,  // w ready
  input wire logic [1:0]  BRESP_OUT,   // b resp
  input wire logic        BVALID_OUT,  // b valid
  input wire logic        BREADY_IN,   // b ready
  input wire logic [7:0]  ARADDR_IN,   // ar addr
  input wire logic        ARVALID_IN,  // ar valid
  input wire logic        ARREADY_OUT, // ar ready
  input wire logic [31:0] RDATA_OUT,   // r data
  input wire logic [1:0]  RRESP_OUT,   // r resp
  input wire logic        RVALID_OUT,  // r valid
  input wire logic        RREADY_IN    // r ready
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence aw_w_taken;
    AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
  endsequence
  sequence ar_taken;
    ARVALID_IN && ARREADY_OUT;
  endsequence
  sequence b_done;
    BVALID_OUT && BREADY_IN;
  endsequence
  sequence r_done;
    RVALID_OUT && RREADY_IN;
  endsequence
  bvalid_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read data dropped early");
  write_answer_a: assert property (aw_w_taken |=> !BVALID_OUT && !AWREADY_OUT && !WREADY_OUT ##1 BVALID_OUT)
    else $error("write response late");
  read_answer_a: assert property (ar_taken |=> RVALID_OUT && !ARREADY_OUT)
    else $error("read data late");
  wr_reopen_a: assert property (b_done |=> !BVALID_OUT ##[0:1] (AWREADY_OUT && WREADY_OUT))
    else $error("write channel not reopened");
  rd_reopen_a: assert property (r_done |=> !RVALID_OUT ##[0:1] ARREADY_OUT)
    else $error("read channel not reopened");
  busy_closed_a: assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
    else $error("write taken while response pending");
  unmapped_rd_a: assert property (ARVALID_IN && ARREADY_OUT && ARADDR_IN == 8'h30
    |=> RRESP_OUT == 2'b10 && RDATA_OUT == 32'h0000_0000)
    else $error("unmapped read not refused");
  kind_range_a: assert property (ARVALID_IN && ARREADY_OUT && ARADDR_IN == `KLL_A_KIND
    |=> RRESP_OUT == 2'b00 && RDATA_OUT[31:4] == 28'h0)
    else $error("display kind read bad");
endmodule // kll_keypad_checker
bind kll_keypad kll_keypad_checker u_chk (.CLK_IN, .RST_N_IN, .AWVALID_IN, .AWREADY_OUT, .WVALID_IN, .WREADY_OUT,
  .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT,
  .RREADY_IN);
`default_nettype wire

// ---- tb/kll_keypad_linearization_lockout_tb.sv ----
// bench for the keypad, lockout and table entry controller
`timescale 1ns/1ps
`default_nettype none
`include "kll_regs.vh"
module kll_keypad_linearization_lockout_tb;
  logic        CLK_IN = 1'b0, RST_N_IN = 1'b0, AWVALID_IN = 1'b0, WVALID_IN = 1'b0, BREADY_IN = 1'b0;
  logic        ARVALID_IN = 1'b0, RREADY_IN = 1'b0, EXT_RST_IN = 1'b0, go = 1'b0;
  logic [7:0]  AWADDR_IN = 8'h00, ARADDR_IN = 8'h00;
  logic [31:0] WDATA_IN = 32'h0000_0000, rv;
  logic [3:0]  WSTRB_IN = 4'hF, burst = 4'h0;
  logic [1:0]  rr;
  wire         AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT, PULSE_IN;
  wire  [1:0]  BRESP_OUT, RRESP_OUT;
  wire  [31:0] RDATA_OUT;
  int          err_total = 0, comparisons = 0;
  logic [31:0] sc [3] = '{`KLL_UNITY, {16'h0000, `KLL_MIN_SC}, {16'h0000, `KLL_HR_SC}};
  always #12.5 CLK_IN = ~CLK_IN;
  // short message time so lock and error messages fit the run
  kll_keypad #(.MSG_CYC(32'h0000_0008)) DUT (.CLK_IN, .RST_N_IN, .AWADDR_IN, .AWVALID_IN, .AWREADY_OUT, .WDATA_IN,
    .WSTRB_IN, .WVALID_IN, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN, .ARREADY_OUT,
    .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN, .PULSE_IN, .EXT_RST_IN);
  kll_field_src u_src (.clk_in(CLK_IN), .burst_in(burst), .go_in(go), .pulse_out(PULSE_IN));
  task automatic complete_run;
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge CLK_IN);
    AWADDR_IN <= a;
    WDATA_IN <= d;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    do begin
      @(posedge CLK_IN);
      if (!aw && AWREADY_OUT) begin
        aw = 1'b1;
        AWVALID_IN <= 1'b0;
      end
      if (!w && WREADY_OUT) begin
        w = 1'b1;
        WVALID_IN <= 1'b0;
      end
    end while (!(aw && w));
    while (!BVALID_OUT) @(posedge CLK_IN);
    rr = BRESP_OUT;
    BREADY_IN <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_IN);
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (ARREADY_OUT) ARVALID_IN <= 1'b0;
    end while (!RVALID_OUT);
    rv = RDATA_OUT;
    rr = RRESP_OUT;
    RREADY_IN <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask
  // hex letters a..f give confirm, erase, view, start, stop, menu
  task automatic keys(input string s);
    logic [7:0] c;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      wr(`KLL_A_KEY, {24'h00_0000, (c > 8'h39) ? c - 8'h57 : c - 8'h30});
    end
  endtask
  task automatic pulses(input logic [3:0] n);
    @(posedge CLK_IN);
    burst <= n;
    go <= 1'b1;
    @(posedge CLK_IN);
    go <= 1'b0;
    repeat (2 * n + 8) @(posedge CLK_IN);
  endtask
  initial begin
    repeat (20000) @(posedge CLK_IN);
    err_total++;
    $display("[ERR] t=%0t watchdog expired", $time);
    complete_run;
  end
  initial begin
    repeat (10) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    rc(`KLL_A_LOCK, 32'h0000_1000);
    rc(`KLL_A_KIND, 32'(`KLL_D_NUM));
    rd(8'h30);
    chk(32'(rr), 32'h0000_0002);
    wr(8'h30, 32'h0000_0000);
    chk(32'(rr), 32'h0000_0002);
    keys("1000");
    rc(`KLL_A_KIND, 32'(`KLL_D_LOCKON));
    rc(`KLL_A_LOCK, 32'h0000_0000);
    keys("347191000");
    rc(`KLL_A_KIND, 32'(`KLL_D_LOCKOFF));
    rd(`KLL_A_STAT);
    chk(32'(rv[5]), 32'h0000_0000);
    $display("lock test done");
    keys("c");
    rc(`KLL_A_KIND, 32'(`KLL_D_RATE));
    wr(`KLL_A_RATE, 32'h0000_0005);
    for (int u = 0; u < 3; u++) begin
      wr(`KLL_A_CFG, 32'(u) << 2);
      rc(`KLL_A_DISP, sc[u] * 32'h0000_0005);
    end
    keys("a");
    rc(`KLL_A_KIND, 32'(`KLL_D_GRAND));
    keys("a");
    rc(`KLL_A_KIND, 32'(`KLL_D_RATE));
    keys("c");
    rc(`KLL_A_KIND, 32'(`KLL_D_NUM));
    wr(`KLL_A_CFG, 32'h0000_0000);
    $display("view test done");
    pulses(4'h3);
    rc(`KLL_A_BATCH, 32'h0000_0003);
    keys("1000b");
    rc(`KLL_A_BATCH, 32'h0000_0003);
    keys("ab");
    rc(`KLL_A_GRAND, 32'h0000_0003);
    wr(`KLL_A_CFG, 32'h0000_0001);
    rc(`KLL_A_CFG, 32'h0000_0000);
    keys("fd");
    rd(`KLL_A_STAT);
    chk(32'(rv[2:0]), 32'h0000_0000);
    chk(32'(rv[6]), 32'h0000_0001);
    keys("e");
    rd(`KLL_A_STAT);
    chk(32'(rv[6]), 32'h0000_0000);
    pulses(4'h2);
    rc(`KLL_A_BATCH, 32'h0000_0005);
    rc(`KLL_A_KIND, 32'(`KLL_D_GRAND));
    @(posedge CLK_IN);
    EXT_RST_IN <= 1'b1;
    repeat (4) @(posedge CLK_IN);
    EXT_RST_IN <= 1'b0;
    repeat (4) @(posedge CLK_IN);
    rc(`KLL_A_BATCH, 32'h0000_0000);
    keys("1000b");
    rc(`KLL_A_GRAND, 32'h0000_0000);
    keys("a");
    wr(`KLL_A_PRESET, 32'h0000_0007);
    wr(`KLL_A_CFG, 32'h0000_0001);
    keys("b");
    rc(`KLL_A_BATCH, 32'h0000_0007);
    rc(`KLL_A_DISP, 32'h0000_0007);
    $display("total test done");
    wr(`KLL_A_CFG, 32'h0000_0002);
    keys("fa");
    rc(`KLL_A_KIND, 32'(`KLL_D_WARN));
    rd(`KLL_A_STAT);
    chk(32'(rv[2:0]), 32'h0000_0000);
    wr(`KLL_A_CFG, 32'h0000_0000);
    // three ascending points from zero, then a clean exit
    keys("f1aba1aab10a1aab20a1aba");
    rd(`KLL_A_STAT);
    chk(32'(rv[2:0]), 32'h0000_0000);
    rc(8'h48, 32'h0000_0014);
    keys("f17");
    rc(`KLL_A_DISP, 32'h0000_0011);
    keys("a");
    rd(`KLL_A_STAT);
    chk(32'(rv[11:7]), 32'h0000_0010);
    chk(32'(rv[2:0]), 32'h0000_0002);
    keys("b5");
    rc(`KLL_A_DISP, 32'h0000_0005);
    keys("a2a");
    rd(`KLL_A_STAT);
    chk(32'(rv[2:0]), 32'h0000_0001);
    rc(8'h7C, 32'h0000_0005);
    rc(8'hBC, 32'h0000_0002);
    keys("16a");
    rc(`KLL_A_EFFK, 32'h0000_0002);
    wr(`KLL_A_CFG, 32'h0000_0010);
    rc(`KLL_A_EFFK, `KLL_UNITY);
    wr(`KLL_A_CFG, 32'h0000_0000);
    keys("aaa");
    rc(`KLL_A_KIND, 32'(`KLL_D_SEQERR));
    repeat (30) @(posedge CLK_IN);
    // point four (zero) is not above point three
    rc(`KLL_A_DISP, 32'h0000_0004);
    keys("b");
    rd(`KLL_A_STAT);
    chk(32'(rv[11:7]), 32'h0000_0000);
    $display("table test done");
    complete_run;
  end
endmodule // kll_keypad_linearization_lockout_tb
`default_nettype wire
